/* tor_dest_model.sv */
// destination bus target: takes the presented transaction, retries while stalled
`timescale 1ns/1ps
`default_nettype none
module tor_dest_model (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic stall, // retry every attempt while high
    input wire logic out_valid, // transaction presented
    output logic out_done // non-retry termination
);
    initial out_done = 1'b0;
    // answers a cycle late, like a target decoding before it terminates
    always @(posedge mclk) begin
        out_done <= #1 (!sys_rst && out_valid && !stall);
    end
endmodule : tor_dest_model
`default_nettype wire

/* tor_order.sv */
// ordering and arbitration engine for one forwarding direction of a two-port bridge
// Overview of operation
// RQ1: posted writes leave in exactly the order they were accepted.
// RQ2: delayed read request waits until earlier posted writes complete on target.
// RQ3: delayed read completion waits until earlier posted writes complete.
// RQ4: delayed write request never passes earlier posted write data.
// RQ5: posted writes get chances to pass all delayed requests and completions.
// RQ6: posted queue and delayed queue are chosen by a fair arbiter.
// RQ7: ordering applies only within one direction; other direction is separate.
// RQ8: completions enter this direction's queue, travelling back toward initiator.
// RQ9: delayed requests stay in order; they may pass delayed completions.
// RQ10: completions stay in order; write completions may pass posted writes.
// RQ11: no hardware flush of posted writes tied to interrupts.
// RQ12: software follows each posted write with a read on the same path.
// RQ13: parity checked on incoming words, generated on outgoing words; here outgoing words keep their stored parity bits.
// RQ14: source parity, good or bad, passes unchanged to destination.
// RQ15: parity and system error outputs plus error status on this interface.
// RQ16: entry leaves only on non-retry termination; retry keeps it queued.
// RQ17: posted write acceptance never waits on delayed transactions.
// RQ18: writes are never combined, merged or collapsed.
// RQ19: when both queues are eligible, priority alternates between them.
`timescale 1ns/1ps
`default_nettype none
`include "tor_regs.svh"
module tor_order
    import tor_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic pw_valid, // posted write offered
    output logic pw_ready, // posted write accepted
    input var tor_txn_t pw_txn, // posted write
    input wire logic dreq_valid, // delayed request offered
    output logic dreq_ready, // delayed request accepted
    input var tor_txn_t dreq_txn, // delayed read or write request
    input wire logic dcpl_valid, // delayed completion offered
    output logic dcpl_ready, // delayed completion accepted
    input var tor_txn_t dcpl_txn, // delayed read or write completion
    output logic out_valid, // transaction presented on destination
    output tor_txn_t out_txn, // transaction with forwarded parity
    input wire logic out_done, // non-retry termination on destination
    input wire logic perr_resp, // parity error response enable
    input wire logic serr_en, // system error enable
    input wire logic stat_clr, // clears error status
    output logic perr_n, // data parity error, low active
    output logic serr_n, // system error, low active
    output logic stat_par_det, // sticky parity error detected
    output logic stat_serr_sig // sticky system error signalled
);
    localparam int NQ = 2; // queue 0 requests, queue 1 completions

    // posted queue
    logic pwq_v, pwq_pop;
    tor_txn_t pwq_txn;
    // delayed queues
    tor_txn_t dq_mem [NQ][`TOR_DQ_DEPTH];
    logic [`TOR_OUT_W-1:0] dq_ahead [NQ][`TOR_DQ_DEPTH];
    logic [`TOR_OUT_W-1:0] next_dq_ahead [NQ][`TOR_DQ_DEPTH];
    logic [`TOR_DQ_AW-1:0] dq_wr [NQ], dq_rd [NQ], next_dq_wr [NQ], next_dq_rd [NQ];
    logic [`TOR_DQ_CW-1:0] dq_cnt [NQ], next_dq_cnt [NQ];
    logic dq_push [NQ], dq_pop [NQ], dq_elig [NQ];
    logic next_dreq_ready, next_dcpl_ready;
    // ordering and arbitration
    logic [`TOR_OUT_W-1:0] pw_out, next_pw_out, ahead_new;
    logic pw_leave;
    logic last_pw, next_last_pw, last_cpl, next_last_cpl;
    logic del_v, del_q, pick_pw, grant;
    tor_txn_t del_txn, sel_txn;
    logic sk_ready;
    // parity
    logic a_bad, d_bad;
    logic [2:0] chk_take;
    wire [2:0] a_bad_ch, d_bad_ch;
    tor_txn_t chk_in [3];
    logic [`TOR_PERR_DELAY-1:0] perr_pipe, next_perr_pipe;
    logic next_perr_n, next_serr_n, next_par_det, next_serr_sig;

    tor_pw_fifo u_pwq (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(pw_valid),
        .in_ready(pw_ready),
        .in_txn(pw_txn),
        .out_valid(pwq_v),
        .out_txn(pwq_txn),
        .out_pop(pwq_pop)
    );

    // a posted write counts as complete only when the destination ends it
    assign pw_leave = out_valid && out_done && (out_txn.kind == TOR_PW); // RQ16
    assign dq_push[0] = dreq_valid && dreq_ready;
    assign dq_push[1] = dcpl_valid && dcpl_ready; // RQ8
    // writes still between acceptance and completion, this direction only
    assign ahead_new = pw_leave ? pw_out - 1'b1 : pw_out; // RQ7

    genvar gq, gi;
    generate
        for (gq = 0; gq < NQ; gq++) begin : g_q
            for (gi = 0; gi < `TOR_DQ_DEPTH; gi++) begin : g_e
                always_comb begin
                    next_dq_ahead[gq][gi] = dq_ahead[gq][gi];
                    if (dq_push[gq] && dq_wr[gq] == `TOR_DQ_AW'(gi)) begin
                        // write completions are free to pass posted writes
                        if (gq == 1 && dcpl_txn.kind == TOR_DWC) begin // RQ10
                            next_dq_ahead[gq][gi] = '0;
                        end else begin
                            next_dq_ahead[gq][gi] = ahead_new; // RQ2 RQ3 RQ4
                        end
                    end else if (pw_leave && dq_ahead[gq][gi] != '0) begin
                        next_dq_ahead[gq][gi] = dq_ahead[gq][gi] - 1'b1; // RQ2 RQ3 RQ4
                    end
                end
            end
            assign dq_elig[gq] = (dq_cnt[gq] != '0) && (dq_ahead[gq][dq_rd[gq]] == '0);
        end
    endgenerate

    // delayed side: requests and completions may pass one another
    always_comb begin
        del_q = 1'b0;
        if (dq_elig[0] && dq_elig[1]) begin
            del_q = !last_cpl; // RQ9 RQ10
        end else begin
            del_q = dq_elig[1];
        end
        del_v = dq_elig[0] || dq_elig[1];
        del_txn = dq_mem[del_q][dq_rd[del_q]]; // RQ9
    end

    always_comb begin
        if (pwq_v && del_v) begin
            pick_pw = !last_pw; // RQ5 RQ6 RQ19
        end else begin
            pick_pw = pwq_v;
        end
        grant = sk_ready && (pwq_v || del_v);
        sel_txn = pick_pw ? pwq_txn : del_txn; // RQ14
        pwq_pop = grant && pick_pw; // RQ1
        dq_pop[0] = grant && !pick_pw && !del_q;
        dq_pop[1] = grant && !pick_pw && del_q;
        next_last_pw = last_pw;
        next_last_cpl = last_cpl;
        if (grant && pwq_v && del_v) begin
            next_last_pw = pick_pw; // RQ19
        end
        if (grant && !pick_pw && dq_elig[0] && dq_elig[1]) begin
            next_last_cpl = del_q;
        end
        next_pw_out = pw_out;
        if ((pw_valid && pw_ready) && !pw_leave) begin
            next_pw_out = pw_out + 1'b1;
        end else if (!(pw_valid && pw_ready) && pw_leave) begin
            next_pw_out = pw_out - 1'b1;
        end
    end

    always_comb begin
        for (int q = 0; q < NQ; q++) begin
            next_dq_wr[q] = dq_push[q] ? dq_wr[q] + 1'b1 : dq_wr[q];
            next_dq_rd[q] = dq_pop[q] ? dq_rd[q] + 1'b1 : dq_rd[q];
            next_dq_cnt[q] = dq_cnt[q];
            if (dq_push[q] && !dq_pop[q]) begin
                next_dq_cnt[q] = dq_cnt[q] + 1'b1;
            end else if (dq_pop[q] && !dq_push[q]) begin
                next_dq_cnt[q] = dq_cnt[q] - 1'b1;
            end
        end
        next_dreq_ready = (next_dq_cnt[0] != `TOR_DQ_CW'(`TOR_DQ_DEPTH));
        next_dcpl_ready = (next_dq_cnt[1] != `TOR_DQ_CW'(`TOR_DQ_DEPTH));
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int q = 0; q < NQ; q++) begin
                dq_wr[q] <= '0;
                dq_rd[q] <= '0;
                dq_cnt[q] <= '0;
                for (int i = 0; i < `TOR_DQ_DEPTH; i++) begin
                    dq_ahead[q][i] <= '0;
                end
            end
            dreq_ready <= 1'b0;
            dcpl_ready <= 1'b0;
            pw_out <= '0;
            last_pw <= 1'b0;
            last_cpl <= 1'b0;
        end else begin
            dq_wr <= next_dq_wr;
            dq_rd <= next_dq_rd;
            dq_cnt <= next_dq_cnt;
            dq_ahead <= next_dq_ahead;
            dreq_ready <= next_dreq_ready;
            dcpl_ready <= next_dcpl_ready;
            pw_out <= next_pw_out;
            last_pw <= next_last_pw;
            last_cpl <= next_last_cpl;
        end
    end

    always_ff @(posedge mclk) begin
        if (dq_push[0]) begin
            dq_mem[0][dq_wr[0]] <= dreq_txn;
        end
        if (dq_push[1]) begin
            dq_mem[1][dq_wr[1]] <= dcpl_txn;
        end
    end

    // destination takes an entry only on a non-retry end; retry holds it
    tor_skid u_out (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(grant),
        .in_ready(sk_ready),
        .in_txn(sel_txn),
        .out_valid(out_valid),
        .out_txn(out_txn),
        .out_ready(out_done) // RQ16
    );

    // parity is only checked here; stored parity bits travel untouched,
    // so bad parity on the source reappears on the destination
    assign chk_take = {dq_push[1], dq_push[0], pw_valid && pw_ready};
    assign chk_in[0] = pw_txn;
    assign chk_in[1] = dreq_txn;
    assign chk_in[2] = dcpl_txn;

    // every input is checked, so words taken in the same cycle are all seen
    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_chk
            assign a_bad_ch[gc] = chk_take[gc]
                && ((^chk_in[gc].addr) != chk_in[gc].apar); // RQ13
            assign d_bad_ch[gc] = chk_take[gc]
                && ((^{chk_in[gc].data, chk_in[gc].cbe}) != chk_in[gc].dpar); // RQ13
        end
    endgenerate

    always_comb begin
        a_bad = |a_bad_ch;
        d_bad = |d_bad_ch;
        next_perr_pipe = {perr_pipe[`TOR_PERR_DELAY-2:0], d_bad && perr_resp};
        next_perr_n = !perr_pipe[`TOR_PERR_DELAY-1]; // RQ15
        next_serr_n = !(a_bad && serr_en && perr_resp); // RQ15
        // a new event outranks a clear in the same cycle
        next_par_det = (stat_par_det && !stat_clr) || a_bad || d_bad; // RQ15
        next_serr_sig = (stat_serr_sig && !stat_clr) || !next_serr_n; // RQ15
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            perr_pipe <= '0;
            perr_n <= 1'b1;
            serr_n <= 1'b1;
            stat_par_det <= 1'b0;
            stat_serr_sig <= 1'b0;
        end else begin
            perr_pipe <= next_perr_pipe;
            perr_n <= next_perr_n;
            serr_n <= next_serr_n;
            stat_par_det <= next_par_det;
            stat_serr_sig <= next_serr_sig;
        end
    end
    // interrupts are not held back for posted data: software must read back // RQ11
endmodule : tor_order
`default_nettype wire

/* tor_order_sva.sv */
// port-level assertions for the ordering engine
`timescale 1ns/1ps
`default_nettype none
module tor_order_sva
    import tor_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic pw_valid, // posted write offered
    input wire logic pw_ready, // posted write slot free
    input var tor_txn_t pw_txn, // posted write
    input wire logic dreq_valid, // delayed request offered
    input wire logic dcpl_valid, // delayed completion offered
    input wire logic out_valid, // transaction presented
    input var tor_txn_t out_txn, // presented transaction
    input wire logic out_done, // non-retry termination
    input wire logic perr_resp, // parity response enable
    input wire logic serr_en, // system error enable
    input wire logic stat_clr, // status clear
    input wire logic perr_n, // data parity error
    input wire logic serr_n, // system error
    input wire logic stat_par_det, // sticky parity status
    input wire logic stat_serr_sig // sticky system error status
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_bad_data;
        pw_valid && pw_ready && ((^{pw_txn.data, pw_txn.cbe}) != pw_txn.dpar);
    endsequence
    sequence s_bad_addr;
        pw_valid && pw_ready && perr_resp && serr_en && ((^pw_txn.addr) != pw_txn.apar);
    endsequence

    chk_out_hold: assert property (out_valid && !out_done |=> out_valid && $stable(out_txn))
        else $error("presented transaction changed before termination");
    chk_perr_pulse: assert property (s_bad_data ##0 perr_resp |-> ##[1:5] !perr_n)
        else $error("no parity error pulse after bad data");
    chk_perr_quiet: assert property (!perr_resp [*5] |-> perr_n)
        else $error("parity error pulse while response disabled");
    chk_serr_pulse: assert property (s_bad_addr |-> ##[1:2] !serr_n)
        else $error("no system error after bad address parity");
    chk_serr_status: assert property (!serr_n |-> ##[0:1] stat_serr_sig)
        else $error("system error not recorded in status");
    chk_par_detect: assert property (s_bad_data |=> stat_par_det)
        else $error("parity status not set");
    chk_par_sticky: assert property (stat_par_det && !stat_clr |=> stat_par_det)
        else $error("parity status lost without clear");
    chk_stat_clear: assert property (stat_clr && !pw_valid && !dreq_valid && !dcpl_valid
        |=> !stat_par_det && !stat_serr_sig)
        else $error("status not cleared");
    chk_pw_fall: assert property ($fell(pw_ready) |-> $past(pw_valid))
        else $error("posted slot lost without a posted write");
    chk_ready_rst: assert property ($fell(sys_rst) |-> ##[0:2] pw_ready)
        else $error("posted slot not offered after reset");
endmodule : tor_order_sva
`default_nettype wire

/* tor_order_tb.sv */
// self-checking bench for the ordering engine
`timescale 1ns/1ps
`default_nettype none
module tor_order_tb;
    import tor_pkg::*;
    logic mclk, sys_rst, stall, perr_resp, serr_en, stat_clr, saw_perr, saw_serr;
    logic [2:0] vld;
    wire [2:0] rdy;
    tor_txn_t txn [3];
    tor_txn_t out_txn;
    logic out_valid, out_done, perr_n, serr_n, stat_par_det, stat_serr_sig;
    tor_txn_t got [$];
    int n_errors = 0;
    int checks_done = 0;

    tor_order i_tor_order (.mclk(mclk), .sys_rst(sys_rst),
        .pw_valid(vld[0]), .pw_ready(rdy[0]), .pw_txn(txn[0]),
        .dreq_valid(vld[1]), .dreq_ready(rdy[1]), .dreq_txn(txn[1]),
        .dcpl_valid(vld[2]), .dcpl_ready(rdy[2]), .dcpl_txn(txn[2]),
        .out_valid(out_valid), .out_txn(out_txn), .out_done(out_done),
        .perr_resp(perr_resp), .serr_en(serr_en), .stat_clr(stat_clr), .perr_n(perr_n),
        .serr_n(serr_n), .stat_par_det(stat_par_det), .stat_serr_sig(stat_serr_sig));
    tor_dest_model i_tor_dest_model (.mclk(mclk), .sys_rst(sys_rst), .stall(stall),
        .out_valid(out_valid), .out_done(out_done));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (out_valid === 1'b1 && out_done === 1'b1) got.push_back(out_txn);
        if (perr_n === 1'b0) saw_perr = 1'b1;
        if (serr_n === 1'b0) saw_serr = 1'b1;
    end

    function automatic tor_txn_t mk(input tor_kind_t k, input logic [7:0] n, input logic [1:0] bad);
        tor_txn_t t;
        t.kind = k;
        t.addr = 32'h0000_4000;
        t.data = 32'hA5A5_0000 + {24'h00_0000, n};
        t.cbe = n[3:0];
        t.apar = (^t.addr) ^ bad[1];
        t.dpar = (^{t.data, t.cbe}) ^ bad[0];
        return t;
    endfunction : mk

    function automatic int pos(input tor_txn_t t);
        foreach (got[i]) begin
            if (got[i] === t) return i;
        end
        return 99;
    endfunction : pos

    task automatic cmp_txn(input string what, input tor_txn_t e, input tor_txn_t g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_txn

    task automatic cmp_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask : cmp_bit

    // offer stays up afterwards so the next offer can follow back to back
    task automatic put(input int g, input tor_txn_t t);
        int n;
        n = 0;
        vld[g] = 1'b1;
        txn[g] = t;
        do begin
            @(posedge mclk);
            n++;
        end while (rdy[g] !== 1'b1 && n < 100);
        cmp_bit("offer taken", 1'b1, rdy[g]);
        #1;
    endtask : put

    task automatic wait_out(input int n);
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (got.size() < n && k < 200);
        #1;
        cmp_bit("output count", 1'b1, got.size() == n);
    endtask : wait_out

    task automatic t_posted_order();
        tor_txn_t e [4];
        foreach (e[i]) e[i] = mk(TOR_PW, 8'(i), 2'(i % 3));
        got.delete();
        foreach (e[i]) put(0, e[i]);
        vld[0] = 1'b0;
        wait_out(4);
        foreach (e[i]) cmp_txn("posted write", e[i], got[i]);
        $display("test posted_order done");
    endtask : t_posted_order

    task automatic t_delayed_wait();
        tor_txn_t p0, p1, p2, p3, rr, wr, rc;
        p0 = mk(TOR_PW, 8'h10, 2'b00);
        p1 = mk(TOR_PW, 8'h11, 2'b00);
        p2 = mk(TOR_PW, 8'h15, 2'b00);
        p3 = mk(TOR_PW, 8'h16, 2'b00);
        rr = mk(TOR_DRR, 8'h12, 2'b00);
        wr = mk(TOR_DWR, 8'h13, 2'b00);
        rc = mk(TOR_DRC, 8'h14, 2'b00);
        got.delete();
        stall = 1'b1;
        put(0, p0);
        put(0, p1);
        put(0, p2);
        put(0, p3);
        vld[0] = 1'b0;
        put(1, rr);
        put(1, wr);
        vld[1] = 1'b0;
        put(2, rc);
        vld[2] = 1'b0;
        repeat (4) @(posedge mclk);
        #1 stall = 1'b0;
        wait_out(7);
        cmp_txn("first out", p0, got[0]);
        cmp_txn("second out", p1, got[1]);
        cmp_txn("third out", p2, got[2]);
        cmp_txn("fourth out", p3, got[3]);
        cmp_bit("request order", 1'b1, pos(rr) < pos(wr) && pos(wr) < 99);
        cmp_bit("completion out", 1'b1, pos(rc) > 3 && pos(rc) < 99);
        $display("test delayed_wait done");
    endtask : t_delayed_wait

    task automatic t_fair_mix();
        tor_txn_t p [6];
        tor_txn_t c [2];
        foreach (p[i]) p[i] = mk(TOR_PW, 8'(8'h20 + i), 2'b00);
        foreach (c[i]) c[i] = mk(TOR_DWC, 8'(8'h30 + i), 2'b00);
        got.delete();
        stall = 1'b1;
        foreach (p[i]) put(0, p[i]);
        vld[0] = 1'b0;
        repeat (4) @(posedge mclk);
        #1 cmp_bit("posted queue full", 1'b0, rdy[0]);
        foreach (c[i]) put(2, c[i]);
        vld[2] = 1'b0;
        repeat (4) @(posedge mclk);
        #1 stall = 1'b0;
        wait_out(8);
        for (int i = 1; i < 6; i++) cmp_bit("pw order", 1'b1, pos(p[i - 1]) < pos(p[i]));
        cmp_bit("cpl order", 1'b1, pos(c[0]) < pos(c[1]));
        cmp_bit("cpl passes pw", 1'b1, pos(c[0]) < pos(p[5]));
        cmp_bit("alternation", 1'b1, pos(c[1]) < pos(p[5]));
        $display("test fair_mix done");
    endtask : t_fair_mix

    task automatic t_parity_err();
        perr_resp = 1'b1;
        serr_en = 1'b1;
        stat_clr = 1'b1;
        @(posedge mclk);
        #1 stat_clr = 1'b0;
        saw_perr = 1'b0;
        saw_serr = 1'b0;
        got.delete();
        put(0, mk(TOR_PW, 8'h40, 2'b01));
        vld[0] = 1'b0;
        repeat (6) @(posedge mclk);
        #1 cmp_bit("perr pulse", 1'b1, saw_perr);
        cmp_bit("serr quiet", 1'b0, saw_serr);
        cmp_bit("parity status", 1'b1, stat_par_det);
        put(0, mk(TOR_PW, 8'h41, 2'b10));
        vld[0] = 1'b0;
        repeat (6) @(posedge mclk);
        #1 cmp_bit("serr pulse", 1'b1, saw_serr);
        cmp_bit("serr status", 1'b1, stat_serr_sig);
        wait_out(2);
        cmp_txn("bad parity forwarded", mk(TOR_PW, 8'h41, 2'b10), got[1]);
        stat_clr = 1'b1;
        @(posedge mclk);
        #1 stat_clr = 1'b0;
        cmp_bit("status cleared", 1'b0, stat_par_det | stat_serr_sig);
        put(1, mk(TOR_DRR, 8'h42, 2'b01));
        vld[1] = 1'b0;
        repeat (4) @(posedge mclk);
        #1 cmp_bit("request parity", 1'b1, stat_par_det);
        perr_resp = 1'b0;
        serr_en = 1'b0;
        $display("test parity_err done");
    endtask : t_parity_err

    task automatic t_pw_bypass();
        tor_txn_t d [4];
        tor_txn_t w;
        foreach (d[i]) d[i] = mk((i % 2) ? TOR_DWR : TOR_DRR, 8'(8'h50 + i), 2'b00);
        w = mk(TOR_PW, 8'h60, 2'b00);
        got.delete();
        stall = 1'b1;
        foreach (d[i]) put(1, d[i]);
        vld[1] = 1'b0;
        cmp_bit("pw slot with backlog", 1'b1, rdy[0]);
        put(0, w);
        vld[0] = 1'b0;
        stall = 1'b0;
        wait_out(5);
        for (int i = 1; i < 4; i++) cmp_bit("req order", 1'b1, pos(d[i - 1]) < pos(d[i]));
        $display("test pw_bypass done");
    endtask : t_pw_bypass

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(5 * 20000);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run();
    end

    initial begin
        sys_rst = 1'b1;
        vld = 3'b000;
        foreach (txn[i]) txn[i] = '0;
        {stall, perr_resp, serr_en, stat_clr, saw_perr, saw_serr} = 6'h00;
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        t_posted_order();
        t_delayed_wait();
        t_fair_mix();
        t_parity_err();
        t_pw_bypass();
        complete_run();
    end
endmodule : tor_order_tb

bind tor_order tor_order_sva i_tor_order_sva (.mclk(mclk), .sys_rst(sys_rst),
    .pw_valid(pw_valid), .pw_ready(pw_ready), .pw_txn(pw_txn), .dreq_valid(dreq_valid),
    .dcpl_valid(dcpl_valid), .out_valid(out_valid), .out_txn(out_txn), .out_done(out_done),
    .perr_resp(perr_resp), .serr_en(serr_en), .stat_clr(stat_clr), .perr_n(perr_n),
    .serr_n(serr_n), .stat_par_det(stat_par_det), .stat_serr_sig(stat_serr_sig));
`default_nettype wire

/* tor_pkg.sv */
// types shared by the ordering engine and its queues
package tor_pkg;

    typedef enum logic [2:0] {
        TOR_PW,
        TOR_DRR,
        TOR_DWR,
        TOR_DRC,
        TOR_DWC
    } tor_kind_t;

    typedef struct packed {
        tor_kind_t kind;
        logic [31:0] addr;
        logic apar;
        logic [31:0] data;
        logic [3:0] cbe;
        logic dpar;
    } tor_txn_t;

endpackage : tor_pkg

/* tor_pw_fifo.sv */
// in-order posted write queue, never combines entries
`timescale 1ns/1ps
`default_nettype none
`include "tor_regs.svh"
module tor_pw_fifo
    import tor_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic in_valid, // write offered
    output logic in_ready, // room for one more
    input var tor_txn_t in_txn, // write to store
    output logic out_valid, // head present
    output tor_txn_t out_txn, // head entry
    input wire logic out_pop // head taken
);
    tor_txn_t mem [`TOR_PW_DEPTH];
    logic [`TOR_PW_AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [`TOR_PW_CW-1:0] cnt, next_cnt;
    logic next_in_ready;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_pop && out_valid;
    assign out_valid = (cnt != '0);
    assign out_txn = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_cnt = cnt;
        if (push) begin
            next_wr_ptr = wr_ptr + 1'b1; // RQ1 RQ18
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1; // RQ1
        end
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
        // acceptance depends on room alone, never on delayed traffic
        next_in_ready = (next_cnt != `TOR_PW_CW'(`TOR_PW_DEPTH)); // RQ17
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            cnt <= next_cnt;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_txn;
        end
    end
endmodule : tor_pw_fifo
`default_nettype wire

/* tor_regs.svh */
// queue depths, pointer widths and timing counts for the ordering engine
`ifndef TOR_REGS_SVH
`define TOR_REGS_SVH

`define TOR_PW_DEPTH 4
`define TOR_PW_AW 2
`define TOR_PW_CW 3
`define TOR_DQ_DEPTH 4
`define TOR_DQ_AW 2
`define TOR_DQ_CW 3
`define TOR_OUT_W 3
`define TOR_PERR_DELAY 2

`endif

/* tor_skid.sv */
// two-entry buffer toward the target bus, registered on both sides
`timescale 1ns/1ps
`default_nettype none
module tor_skid
    import tor_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic in_valid, // word offered
    output logic in_ready, // spare slot free
    input var tor_txn_t in_txn, // word in
    output logic out_valid, // word presented
    output tor_txn_t out_txn, // word out
    input wire logic out_ready // receiver takes it
);
    logic spare_v, next_spare_v, next_out_valid, next_in_ready;
    tor_txn_t spare, next_spare, next_out_txn;
    logic take, give;

    assign take = in_valid && in_ready;
    assign give = out_valid && out_ready;

    always_comb begin
        next_out_valid = out_valid;
        next_out_txn = out_txn;
        next_spare_v = spare_v;
        next_spare = spare;
        if (give || !out_valid) begin
            if (spare_v) begin
                next_out_txn = spare;
                next_spare_v = 1'b0;
                next_out_valid = 1'b1;
                if (take) begin
                    next_spare = in_txn;
                    next_spare_v = 1'b1;
                end
            end else begin
                next_out_valid = take;
                next_out_txn = take ? in_txn : out_txn;
            end
        end else if (take) begin
            // receiver stalled: park the word so nothing is lost
            next_spare = in_txn;
            next_spare_v = 1'b1;
        end
        next_in_ready = !next_spare_v;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            spare_v <= 1'b0;
            in_ready <= 1'b0;
            out_txn <= '0;
            spare <= '0;
        end else begin
            out_valid <= next_out_valid;
            spare_v <= next_spare_v;
            in_ready <= next_in_ready;
            out_txn <= next_out_txn;
            spare <= next_spare;
        end
    end
endmodule : tor_skid
`default_nettype wire
